/* rtl/servo_ctrl_pkg.sv */
// package: register map, field positions, reset values and timing for the servo/enable block
`default_nettype none
package servo_ctrl_pkg;
  // ---------------------------------------------------------------
  // register byte addresses (one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLE = 8'h14;    // load command bit and software enable
  localparam logic [7:0] ADDR_SERVO_CFG = 8'h24; // divider select and discharge select
  localparam logic [7:0] ADDR_VTGT_HI = 8'h28;   // upper eight voltage target bits
  localparam logic [7:0] ADDR_VTGT_LO = 8'h2c;   // lower three voltage target bits
  localparam logic [7:0] ADDR_CURRENT_LIMIT_PIN_CODE = 8'h30; // current limit code
  localparam logic [7:0] ADDR_VREF_NOW = 8'h40;  // status: live voltage counter
  localparam logic [7:0] ADDR_IREF_NOW = 8'h44;  // status: live current counter
  localparam logic [7:0] ADDR_STATUS = 8'h48;    // status: enable, discharge, good, ramping
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int EN_SW_BIT = 0;
  localparam int LOAD_BIT = 1;
  localparam int DIS_SEL_BIT = 4;
  localparam int DIV_LSB = 6;
  localparam int VLO_WIDTH = 3;
  localparam int VHI_WIDTH = 8;
  localparam int ST_EN_BIT = 0;
  localparam int ST_DIS_BIT = 1;
  localparam int ST_PG_BIT = 2;
  localparam int ST_VRAMP_BIT = 3;
  localparam int ST_IRAMP_BIT = 4;
  localparam int ST_BUSY_BIT = 5;
  // ---------------------------------------------------------------
  // codes and reset values
  // ---------------------------------------------------------------
  localparam logic [10:0] VCODE_MAX = 11'h780; // codes above this are clamped
  localparam logic [10:0] VCODE_MIN = 11'h0f0; // below this the output is under 3 V
  localparam logic [7:0] RST_VTGT_HI = 8'h00;
  localparam logic [2:0] RST_VTGT_LO = 3'h0;
  localparam logic [7:0] RST_CURRENT_LIMIT_PIN = 8'h00;
  localparam logic [1:0] RST_DIV = 2'h0;
  // divide ratios per select code, increasing
  localparam logic [7:0] DIV_RATIO0 = 8'h02;
  localparam logic [7:0] DIV_RATIO1 = 8'h04;
  localparam logic [7:0] DIV_RATIO2 = 8'h08;
  localparam logic [7:0] DIV_RATIO3 = 8'h10;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SERVO_MASTER_NS = 40; // servo master clock period
  localparam int SERVO_MASTER_CYC = (SERVO_MASTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 3;
endpackage
`default_nettype wire

/* rtl/servo_tick_div.sv */
// servo clock divider: master tick then a selectable divide ratio
`default_nettype none
module servo_tick_div #(
  parameter int MASTER_CYC = servo_ctrl_pkg::SERVO_MASTER_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] div_sel,
  output logic tick
);
  initial
  begin
    if (MASTER_CYC < 1 || MASTER_CYC > 255)
      $error("servo_tick_div: MASTER_CYC out of range");
  end
  // ---------------------------------------------------------------
  // master prescaler
  // ---------------------------------------------------------------
  localparam logic [7:0] MASTER_LAST = 8'(MASTER_CYC - 1);
  logic [7:0] pre_reg; // master prescale count
  logic [7:0] div_reg; // ratio count
  wire master_tick = (pre_reg == MASTER_LAST);
  // ratio lookup, the code wins a slower or faster ramp
  wire [7:0] ratio = (div_sel == 2'h0) ? servo_ctrl_pkg::DIV_RATIO0 :
                     (div_sel == 2'h1) ? servo_ctrl_pkg::DIV_RATIO1 :
                     (div_sel == 2'h2) ? servo_ctrl_pkg::DIV_RATIO2 :
                     servo_ctrl_pkg::DIV_RATIO3;
  // >= guards a ratio lowered while the count is high
  wire div_wrap = master_tick && (div_reg >= ratio - 8'h01);
  // prescaler and divider counts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_reg <= 8'h00;
      div_reg <= 8'h00;
    end
    else
    begin
      pre_reg <= master_tick ? 8'h00 : pre_reg + 8'h01;
      if (div_wrap)
        div_reg <= 8'h00;
      else if (master_tick)
        div_reg <= div_reg + 8'h01;
    end
  end
  assign tick = div_wrap;
endmodule
`default_nettype wire

/* rtl/servo_updown.sv */
// up/down counter that steps one code per tick toward its target
`default_nettype none
module servo_updown #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold_zero,
  input wire logic tick,
  input wire logic [W-1:0] target,
  output logic [W-1:0] count,
  output logic equal
);
  initial
  begin
    if (W < 1)
      $error("servo_updown: W must be positive");
  end
  logic [W-1:0] count_reg; // live reference code
  // comparator
  wire up = target > count_reg;
  assign equal = (target == count_reg);
  // step once per tick, hold when equal, cleared while held
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= '0;
    else if (hold_zero)
      count_reg <= '0;
    else if (tick && !equal)
      count_reg <= up ? count_reg + 1'b1 : count_reg - 1'b1;
  end
  assign count = count_reg;
  a_step_one: assert property (@(posedge clk) disable iff (!rst_n)
    !hold_zero && $past(!hold_zero) && $past(tick) && $past(!equal) |->
    (count == $past(count) + 1'b1) || (count == $past(count) - 1'b1))
    else $error("servo counter did not move by one");
  a_hold_eq: assert property (@(posedge clk) disable iff (!rst_n)
    $past(equal) && $past(!hold_zero) && !hold_zero |-> $stable(count))
    else $error("servo counter moved while equal");
endmodule
`default_nettype wire

/* rtl/servo_reference_enable_ctrl.sv */
// servo reference and enable control for the main step-down regulator
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`default_nettype none
module servo_reference_enable_ctrl #(
  parameter int MASTER_CYC = servo_ctrl_pkg::SERVO_MASTER_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pins and analog side
  input wire logic ENABLE_PIN,
  input wire logic BIAS_READY,
  input wire logic OUTPUT_AT_TARGET,
  output logic INTERNAL_ENABLE,
  output logic SWITCH_ENABLE,
  output logic DISCHARGE_RESISTOR,
  output logic [10:0] VOLTAGE_DAC_OUTPUT,
  output logic [7:0] CURRENT_REF_CONVERTER,
  output logic POWER_GOOD,
  output logic BELOW_MIN_CODE
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  // every register below sits behind the asynchronous reset, so the
  // regulator wakes disabled with both references at code zero
  logic [7:0] vtgt_hi_reg; // upper voltage target bits
  logic [2:0] vtgt_lo_reg; // lower voltage target bits
  logic [10:0] vactive_reg; // target adopted at last load
  logic [7:0] current_limit_pin_reg; // current limit code
  logic en_sw_reg; // software enable
  logic dis_sel_reg; // discharge select
  logic [1:0] div_reg; // servo divide select
  logic [31:0] prdata_reg; // read data register
  logic [2:0] pin_sync_reg; // enable pin synchroniser
  logic pin_level_reg; // filtered enable pin level
  logic pg_reg; // power good
  logic sw_en_reg; // switching enable
  logic dis_reg; // discharge drive
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // full eight-bit compare: aliases of a register would hide host
  // address bugs, so anything off the map answers with an error
  wire wr_en = PSEL && PENABLE && PWRITE; // write takes effect in access phase
  wire rd_en = PSEL && PENABLE && !PWRITE;
  wire hit_enable = (PADDR == servo_ctrl_pkg::ADDR_ENABLE);
  wire hit_cfg = (PADDR == servo_ctrl_pkg::ADDR_SERVO_CFG);
  wire hit_vhi = (PADDR == servo_ctrl_pkg::ADDR_VTGT_HI);
  wire hit_vlo = (PADDR == servo_ctrl_pkg::ADDR_VTGT_LO);
  wire hit_current_limit_pin = (PADDR == servo_ctrl_pkg::ADDR_CURRENT_LIMIT_PIN_CODE);
  wire hit_vnow = (PADDR == servo_ctrl_pkg::ADDR_VREF_NOW);
  wire hit_inow = (PADDR == servo_ctrl_pkg::ADDR_IREF_NOW);
  wire hit_stat = (PADDR == servo_ctrl_pkg::ADDR_STATUS);
  wire hit_any = hit_enable | hit_cfg | hit_vhi | hit_vlo | hit_current_limit_pin | hit_vnow |
                 hit_inow | hit_stat;
  wire lane0 = PSTRB[0]; // every field lives in byte lane zero
  wire wr_enable = wr_en && hit_enable && lane0;
  wire wr_cfg = wr_en && hit_cfg && lane0;
  wire wr_vhi = wr_en && hit_vhi && lane0;
  wire wr_vlo = wr_en && hit_vlo && lane0;
  wire wr_current_limit_pin = wr_en && hit_current_limit_pin && lane0;
  // load pulse exists only for the write cycle, so the bit has no storage
  wire load_cmd = wr_enable && PWDATA[servo_ctrl_pkg::LOAD_BIT];
  // ---------------------------------------------------------------
  // target assembly and clamp
  // ---------------------------------------------------------------
  // the halves are only combined here; nothing downstream sees them
  // until a load command copies the clamped word
  wire [10:0] vtgt_raw = {vtgt_hi_reg, vtgt_lo_reg};
  // clamp keeps an over-range code from reaching the reference
  wire [10:0] vtgt_clamped = (vtgt_raw > servo_ctrl_pkg::VCODE_MAX) ?
                             servo_ctrl_pkg::VCODE_MAX : vtgt_raw;
  // ---------------------------------------------------------------
  // enable path
  // ---------------------------------------------------------------
  // the pin is asynchronous, so its level is trusted only after the
  // filter; the software bit is already in this clock domain
  // a change counts once the second and third stages agree
  wire pin_agree = (pin_sync_reg[1] == pin_sync_reg[2]);
  wire pin_level_next = pin_agree ? pin_sync_reg[2] : pin_level_reg;
  // nothing switches until the bias is ready
  wire internal_enable = BIAS_READY && (pin_level_reg || en_sw_reg);
  wire tick; // divided servo tick shared by both channels
  wire [10:0] vcount; // live voltage reference
  wire [7:0] icount; // live current reference
  wire veq; // voltage channel settled
  wire ieq; // current channel settled
  wire sw_en_next = internal_enable;
  wire dis_next = !internal_enable && dis_sel_reg;
  // good only with the ramp done and the analog side in regulation
  wire pg_next = internal_enable && veq && OUTPUT_AT_TARGET;
  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // control and target registers
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      vtgt_hi_reg <= servo_ctrl_pkg::RST_VTGT_HI;
      vtgt_lo_reg <= servo_ctrl_pkg::RST_VTGT_LO;
      current_limit_pin_reg <= servo_ctrl_pkg::RST_CURRENT_LIMIT_PIN;
      en_sw_reg <= 1'b0;
      dis_sel_reg <= 1'b0;
      div_reg <= servo_ctrl_pkg::RST_DIV;
    end
    else
    begin
      if (wr_vhi)
        vtgt_hi_reg <= PWDATA[servo_ctrl_pkg::VHI_WIDTH-1:0];
      if (wr_vlo)
        vtgt_lo_reg <= PWDATA[servo_ctrl_pkg::VLO_WIDTH-1:0];
      if (wr_current_limit_pin)
        current_limit_pin_reg <= PWDATA[7:0];
      if (wr_enable)
        en_sw_reg <= PWDATA[servo_ctrl_pkg::EN_SW_BIT];
      if (wr_cfg)
      begin
        dis_sel_reg <= PWDATA[servo_ctrl_pkg::DIS_SEL_BIT];
        div_reg <= PWDATA[servo_ctrl_pkg::DIV_LSB+1:servo_ctrl_pkg::DIV_LSB];
      end
    end
  end
  // active voltage target, moves only on the load command
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      vactive_reg <= {servo_ctrl_pkg::RST_VTGT_HI, servo_ctrl_pkg::RST_VTGT_LO};
    else if (load_cmd)
      vactive_reg <= vtgt_clamped;
  end
  // ---------------------------------------------------------------
  // pin synchroniser and output flops
  // ---------------------------------------------------------------
  // stage zero feeds only stage one
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pin_sync_reg <= 3'h0;
      pin_level_reg <= 1'b0;
    end
    else
    begin
      pin_sync_reg <= {pin_sync_reg[1:0], ENABLE_PIN};
      pin_level_reg <= pin_level_next;
    end
  end
  // regulator drive outputs
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sw_en_reg <= 1'b0;
      dis_reg <= 1'b0;
      pg_reg <= 1'b0;
    end
    else
    begin
      sw_en_reg <= sw_en_next;
      dis_reg <= dis_next;
      pg_reg <= pg_next;
    end
  end
  // ---------------------------------------------------------------
  // servo channels
  // ---------------------------------------------------------------
  // one divided tick feeds both counters, so a ramp speed change
  // takes effect on both references together
  servo_tick_div #(.MASTER_CYC(MASTER_CYC)) u_div (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .div_sel(div_reg),
    .tick(tick)
  );
  // voltage channel doubles as soft-start: held at zero until enabled
  servo_updown #(.W(11)) u_vchan (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .hold_zero(!internal_enable),
    .tick(tick),
    .target(vactive_reg),
    .count(vcount),
    .equal(veq)
  );
  // current channel runs on its own, so both may ramp together
  servo_updown #(.W(8)) u_ichan (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .hold_zero(1'b0),
    .tick(tick),
    .target(current_limit_pin_reg),
    .count(icount),
    .equal(ieq)
  );
  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // load bit has no storage and so always reads back as zero
  wire [31:0] rd_status = {26'h0, !(veq && ieq), !ieq, !veq, pg_reg, dis_reg, internal_enable};
  wire [31:0] rd_mux = hit_enable ? {31'h0, en_sw_reg} :
                       hit_cfg ? {24'h0, div_reg, 1'b0, dis_sel_reg, 4'h0} :
                       hit_vhi ? {24'h0, vtgt_hi_reg} :
                       hit_vlo ? {29'h0, vtgt_lo_reg} :
                       hit_current_limit_pin ? {24'h0, current_limit_pin_reg} :
                       hit_vnow ? {21'h0, vcount} :
                       hit_inow ? {24'h0, icount} :
                       hit_stat ? rd_status : 32'h0;
  // read data captured in the setup cycle, stable through access
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      prdata_reg <= 32'h0;
    else if (PSEL && !PENABLE && !PWRITE)
      prdata_reg <= rd_mux;
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1; // zero wait states
  assign PSLVERR = PSEL && PENABLE && !hit_any;
  assign INTERNAL_ENABLE = internal_enable;
  assign SWITCH_ENABLE = sw_en_reg;
  assign DISCHARGE_RESISTOR = dis_reg;
  // the analog stage scales by eight, so one code is 12.5 mV out
  assign VOLTAGE_DAC_OUTPUT = vcount;
  // converter adds one step internally: code zero still gives one step
  assign CURRENT_REF_CONVERTER = icount;
  assign POWER_GOOD = pg_reg;
  // low codes are accepted; this flag lets protection act on them
  assign BELOW_MIN_CODE = internal_enable && (vactive_reg < servo_ctrl_pkg::VCODE_MIN);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_load_only: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    !$past(load_cmd) |-> $stable(vactive_reg))
    else $error("active target moved without load");
  a_clamp_max: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    vactive_reg <= servo_ctrl_pkg::VCODE_MAX)
    else $error("active target above maximum");
  a_off_zero: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    !internal_enable ##1 !internal_enable |-> vcount == 11'h000)
    else $error("voltage counter not held at zero");
  a_sw_follow: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    !internal_enable |=> !SWITCH_ENABLE)
    else $error("switching while disabled");
  a_dis_on: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    !internal_enable && dis_sel_reg |=> DISCHARGE_RESISTOR)
    else $error("discharge missing while disabled");
  a_dis_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    !dis_sel_reg || internal_enable |=> !DISCHARGE_RESISTOR)
    else $error("discharge on when not selected");
  a_en_or: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    BIAS_READY && en_sw_reg |-> INTERNAL_ENABLE)
    else $error("software enable ignored");
  a_pg_cause: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    POWER_GOOD |-> $past(internal_enable) && $past(veq))
    else $error("power good without settled ramp");
  a_load_apply: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    load_cmd |=> vactive_reg == $past(vtgt_clamped))
    else $error("load did not adopt target");
  // the pin alone must be enough once the bias is ready
  a_en_pin: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    BIAS_READY && pin_level_reg |-> INTERNAL_ENABLE)
    else $error("pin enable ignored");
  // no enable of any kind before the bias is ready
  a_en_gate: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    !BIAS_READY |-> !INTERNAL_ENABLE)
    else $error("enabled before bias ready");
  // an over-range code loads as the maximum
  a_clamp_load: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    load_cmd && (vtgt_raw > servo_ctrl_pkg::VCODE_MAX) |=>
    vactive_reg == servo_ctrl_pkg::VCODE_MAX)
    else $error("over-range code not clamped");
  // the low-code flag is only raised while enabled
  a_below_en: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    BELOW_MIN_CODE |-> INTERNAL_ENABLE)
    else $error("low code flag while disabled");
  // filter follows the last stage once the two last stages agree
  a_pin_filter: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    pin_agree |=> pin_level_reg == $past(pin_sync_reg[2]))
    else $error("pin filter did not follow");
endmodule
`default_nettype wire

/* dv/servo_host_model.sv */
// host side model: apb master for the registers plus the enable pin driver
`default_nettype none
module servo_host_model #(
  parameter int PIN_LOW_MIN = 8 // shortest pin level the driver ever holds
) (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  output logic enable_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // idle bus; pin open means pulled up
  // ----------------------------------------------------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    enable_pin = 1'b1;
  end
  // one transfer: setup, access until ready, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines stop showing the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // both target halves first, load command last
  task automatic load_target(input logic [7:0] hi, input logic [2:0] lo, input logic en);
    logic [31:0] q;
    logic e;
    xfer(1'b1, servo_ctrl_pkg::ADDR_VTGT_HI, {24'h0, hi}, q, e);
    xfer(1'b1, servo_ctrl_pkg::ADDR_VTGT_LO, {29'h0, lo}, q, e);
    xfer(1'b1, servo_ctrl_pkg::ADDR_ENABLE, {30'h0, 1'b1, en}, q, e);
  endtask
  // short pin pulses could be missed, so every level is held long enough
  task automatic pin_set(input logic v);
    @(posedge clk);
    enable_pin <= v;
    repeat (PIN_LOW_MIN) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* dv/servo_reference_enable_ctrl_tb_top.sv */
// testbench top: register access, servo ramps, enable and discharge paths
`default_nettype none
module servo_reference_enable_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic core_clk = 1'b0; // 250 MHz
  logic rstn = 1'b0; // low for the first cycles
  logic bias_ready = 1'b0;
  logic at_target = 1'b0; // analog side reports output reached
  wire logic psel, penable, pwrite, pready, pslverr, pin;
  wire logic [7:0] paddr;
  wire logic [3:0] pstrb;
  wire logic [31:0] pwdata, prdata;
  wire logic internal_enable, sw_en, dis, pg, below;
  wire logic [10:0] vdac;
  wire logic [7:0] iref;
  int n_errors = 0;
  int checks = 0;
  int cyc_cnt = 0; // timeout counter
  int seed = 27365;
  int n;
  logic [31:0] q;
  logic err;
  logic [7:0] hi, ic;
  logic [2:0] lo;
  logic [7:0] regs [8] = '{servo_ctrl_pkg::ADDR_ENABLE, servo_ctrl_pkg::ADDR_SERVO_CFG,
    servo_ctrl_pkg::ADDR_VTGT_HI, servo_ctrl_pkg::ADDR_VTGT_LO, servo_ctrl_pkg::ADDR_CURRENT_LIMIT_PIN_CODE,
    servo_ctrl_pkg::ADDR_VREF_NOW, servo_ctrl_pkg::ADDR_IREF_NOW, servo_ctrl_pkg::ADDR_STATUS};
  always #2 core_clk = ~core_clk;
  // short master tick keeps ramps brief
  servo_reference_enable_ctrl #(.MASTER_CYC(1)) dut (.CORE_CLK(core_clk), .RSTN(rstn),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ENABLE_PIN(pin),
    .BIAS_READY(bias_ready), .OUTPUT_AT_TARGET(at_target), .INTERNAL_ENABLE(internal_enable),
    .SWITCH_ENABLE(sw_en), .DISCHARGE_RESISTOR(dis), .VOLTAGE_DAC_OUTPUT(vdac),
    .CURRENT_REF_CONVERTER(iref), .POWER_GOOD(pg), .BELOW_MIN_CODE(below));
  servo_host_model host (.clk(core_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .enable_pin(pin));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q, err);
    chk_val(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, err);
  endtask
  // bounded wait for a channel to reach a code; n keeps the cycles taken
  task automatic settle(input logic is_v, input logic [10:0] e);
    n = 0;
    while ((is_v ? vdac : {3'h0, iref}) !== e && n < 6000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk_val({21'h0, is_v ? vdac : {3'h0, iref}}, {21'h0, e});
  endtask
  // expected active code: codes above the maximum are clamped
  function automatic logic [10:0] vexp(input logic [7:0] h, input logic [2:0] l);
    vexp = ({h, l} > servo_ctrl_pkg::VCODE_MAX) ? servo_ctrl_pkg::VCODE_MAX : {h, l};
  endfunction
  function automatic int ratio(input int s);
    case (s)
      0: ratio = int'(servo_ctrl_pkg::DIV_RATIO0);
      1: ratio = int'(servo_ctrl_pkg::DIV_RATIO1);
      2: ratio = int'(servo_ctrl_pkg::DIV_RATIO2);
      default: ratio = int'(servo_ctrl_pkg::DIV_RATIO3);
    endcase
  endfunction
  task automatic end_of_test;
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard, well above the expected run
  always @(posedge core_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 60000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (regs[k]) rd(regs[k], 32'h0);
    host.xfer(1'b0, 8'h3c, 32'h0, q, err);
    chk_bit(err, 1'b1);
    chk_val(q, 32'h0);
    // open pin enables once bias is ready
    @(posedge core_clk);
    bias_ready <= 1'b1;
    cyc(6);
    chk_bit(internal_enable, 1'b1);
    chk_bit(sw_en, 1'b1);
    host.pin_set(1'b0);
    cyc(2);
    chk_bit(sw_en, 1'b0);
    chk_bit(dis, 1'b0);
    wr(servo_ctrl_pkg::ADDR_SERVO_CFG, 32'h10);
    cyc(2);
    chk_bit(dis, 1'b1);
    wr(servo_ctrl_pkg::ADDR_ENABLE, 32'h1);
    cyc(2);
    chk_bit(internal_enable, 1'b1);
    chk_bit(dis, 1'b0);
    // halves alone must not move the active target
    wr(servo_ctrl_pkg::ADDR_VTGT_HI, 32'h02);
    wr(servo_ctrl_pkg::ADDR_VTGT_LO, 32'h5);
    cyc(20);
    chk_val({21'h0, vdac}, 32'h0);
    rd(servo_ctrl_pkg::ADDR_VTGT_HI, 32'h02);
    wr(servo_ctrl_pkg::ADDR_ENABLE, 32'h3);
    rd(servo_ctrl_pkg::ADDR_ENABLE, 32'h1);
    settle(1'b1, 11'h015);
    chk_bit(below, 1'b1);
    // each divide select: eight steps, alternating direction
    wr(servo_ctrl_pkg::ADDR_CURRENT_LIMIT_PIN_CODE, 32'h30);
    settle(1'b0, 11'h030);
    for (int s = 0; s < 4; s++)
    begin
      wr(servo_ctrl_pkg::ADDR_SERVO_CFG, 32'(s * 64 + 16));
      wr(servo_ctrl_pkg::ADDR_CURRENT_LIMIT_PIN_CODE, (s % 2) ? 32'h30 : 32'h38);
      settle(1'b0, (s % 2) ? 11'h030 : 11'h038);
      chk_bit(n >= 7 * ratio(s) - 1 && n <= 9 * ratio(s) + 2, 1'b1);
    end
    // both channels ramp at once
    wr(servo_ctrl_pkg::ADDR_SERVO_CFG, 32'h10);
    host.load_target(8'h20, 3'h0, 1'b1);
    wr(servo_ctrl_pkg::ADDR_CURRENT_LIMIT_PIN_CODE, 32'h90);
    cyc(20);
    chk_bit(vdac != 11'h015 && vdac != 11'h100 && iref != 8'h30, 1'b1);
    settle(1'b1, 11'h100);
    settle(1'b0, 11'h090);
    chk_bit(below, 1'b0);
    // random targets, then the clamp corner
    for (int k = 0; k < 4; k++)
    begin
      hi = (k == 3) ? 8'hff : 8'($random(seed));
      lo = (k == 3) ? 3'h7 : 3'($random(seed));
      ic = 8'($random(seed));
      host.load_target(hi, lo, 1'b1);
      wr(servo_ctrl_pkg::ADDR_CURRENT_LIMIT_PIN_CODE, {24'h0, ic});
      settle(1'b1, vexp(hi, lo));
      settle(1'b0, {3'h0, ic});
      chk_bit(below, vexp(hi, lo) < servo_ctrl_pkg::VCODE_MIN);
    end
    @(posedge core_clk);
    at_target <= 1'b1;
    cyc(3);
    chk_bit(pg, 1'b1);
    // disable: counter cleared, discharge on
    wr(servo_ctrl_pkg::ADDR_ENABLE, 32'h0);
    cyc(2);
    chk_val({21'h0, vdac}, 32'h0);
    chk_bit(sw_en, 1'b0);
    chk_bit(dis, 1'b1);
    chk_bit(pg, 1'b0);
    // pin alone restarts with a soft ramp from zero
    host.pin_set(1'b1);
    chk_bit(internal_enable, 1'b1);
    chk_bit(vdac != 11'h000 && vdac < 11'h780, 1'b1);
    settle(1'b1, 11'h780);
    end_of_test();
  end
endmodule
`default_nettype wire
